// >>> rcpc_pkg.sv
package rcpc_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PWR_STAB_NS = 4_600_000;
  localparam int PWR_STAB_CYC =
    (PWR_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_NS = 8_000_000;
  localparam int DEBOUNCE_CYC =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_WARM_CYC = 2048;
  localparam int SLOW_WARM_TICKS = 5;
  localparam int WDT_TICKS = 256;

  // command codes
  localparam logic [7:0] WDT_CLEAR_CODE = 8'h5a;
  localparam logic [7:0] CLK_APPLY_CODE = 8'h69;

  // register indices, byte address is index times four
  localparam logic [7:0] IDX_WDOG_CLEAR = 8'h86;
  localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
  localparam logic [7:0] IDX_FETCH_WAIT = 8'h8e;
  localparam logic [7:0] IDX_P1_WAKE = 8'h91;
  localparam logic [7:0] IDX_CAUSE_FLAGS = 8'hc0;
  localparam logic [7:0] IDX_SOFT_RESET = 8'hc1;
  localparam logic [7:0] IDX_DIV_SELECT = 8'he5;
  localparam logic [7:0] IDX_CLK_APPLY = 8'he6;

  // field positions
  localparam int POWER_CONTROL_IDLE_BIT = 0;
  localparam int POWER_CONTROL_STOP_BIT = 1;
  localparam int POWER_CONTROL_GF0_BIT = 2;
  localparam int FLAG_LVD_BIT = 7;
  localparam int FLAG_WDT_BIT = 6;
  localparam int FLAG_PIN_BIT = 5;
  localparam int SOFTWARE_RESET_REGISTER_REQ_BIT = 0;
  localparam int FETCH_LSB = 4;

  // reset values and the highest divider code that is applied
  localparam logic [2:0] FETCH_WAIT_RST = 3'h7;
  localparam logic [3:0] FETCH_LOW_BITS = 4'h1;
  localparam logic [2:0] DIV_SELECT_RST = 3'h7;
  localparam logic [2:0] DIV_ACTIVE_RST = 3'h0;
  localparam logic [2:0] DIV_SELECT_MAX = 3'h5;
  localparam logic [7:0] P1_WAKE_RST = 8'h00;

  // watchdog option encodings
  localparam logic [1:0] WDT_MODE_OFF = 2'h0;
  localparam logic [1:0] WDT_MODE_ENABLE = 2'h1;
  localparam logic [1:0] WDT_MODE_ALWAYS = 2'h2;

  typedef enum logic [2:0] {
    SEQ_HOLD,
    SEQ_POWER,
    SEQ_OSC,
    SEQ_SLOW,
    SEQ_RUN,
    SEQ_SOFT
  } rcpc_seq_t;
endpackage

// >>> rcpc_top.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module rcpc_top
  import rcpc_pkg::*;
#(
  parameter int PWR_STAB_CYCLES = PWR_STAB_CYC,
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // option straps
  input wire logic cfgLvdEn,
  input wire logic cfgPinResetEn,
  input wire logic cfgDebounceEn,
  input wire logic [1:0] cfgWdtMode,
  input wire logic [1:0] cfgWdtPrescale,
  // asynchronous inputs
  input wire logic supplyLow,
  input wire logic resetPinN,
  input wire logic slowOscClk,
  input wire logic [7:0] port0In,
  input wire logic [7:0] port1In,
  // same-domain event
  input wire logic irqEvent,
  // system controls
  output logic sysReset,
  output logic cpuRun,
  output logic cpuClkEn,
  output logic fetchEn,
  output logic periphRun,
  output logic fastOscRun
);
  localparam int SEQ_MAX =
    (PWR_STAB_CYCLES > OSC_WARM_CYC) ? PWR_STAB_CYCLES : OSC_WARM_CYC;
  localparam int SEQ_W = $clog2(SEQ_MAX + 1);
  localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);

  generate
    if (PWR_STAB_CYCLES < 1 || DEBOUNCE_CYCLES < 1)
    begin : g_bad_param
      $error("rcpc_top: cycle counts must be at least one");
    end
  endgenerate

  // synchronisers: first stage feeds only the second
  logic [19:0] syncMeta_r;
  logic [19:0] syncOut_r;
  logic slowLast_r;
  logic [7:0] port0Last_r;
  logic [7:0] port1Last_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      syncMeta_r <= 20'h00002;
      syncOut_r <= 20'h00002;
      slowLast_r <= 1'b0;
      port0Last_r <= 8'h00;
      port1Last_r <= 8'h00;
    end
    else if (clkEn)
    begin
      syncMeta_r <= {1'b0, port1In, port0In, slowOscClk, resetPinN,
        supplyLow};
      syncOut_r <= syncMeta_r;
      slowLast_r <= syncOut_r[2];
      port0Last_r <= syncOut_r[10:3];
      port1Last_r <= syncOut_r[18:11];
    end
  end

  logic lowSupply;
  logic pinHigh;
  logic slowTick;
  assign lowSupply = syncOut_r[0];
  assign pinHigh = syncOut_r[1];
  assign slowTick = syncOut_r[2] & ~slowLast_r;

  // state
  rcpc_seq_t seq_r;
  logic [SEQ_W-1:0] seqCnt_r;
  logic [7:0] p1Wake_r;
  logic idle_r;
  logic stop_r;
  logic gf0_r;
  logic [2:0] divSelect_r;
  logic [2:0] divActive_r;
  logic [2:0] fetchWait_r;
  logic [2:0] causeFlags_r;
  logic softFlag_r;
  logic softArmed_r;
  logic softReq_r;
  logic wdtFire_r;
  logic [4:0] wdtPre_r;
  logic [7:0] wdtCnt_r;
  logic [DEB_W-1:0] debCnt_r;
  logic debDone_r;
  logic [6:0] divCnt_r;
  logic [2:0] fetchCnt_r;

  // apb decode
  logic [7:0] regIdx;
  logic mapped;
  logic setup;
  logic wrAccess;
  logic [7:0] wrByte;
  assign regIdx = paddr[9:2];
  assign setup = psel & ~penable;
  assign wrAccess = psel & penable & pready & pwrite;
  assign wrByte = pwdata[7:0];

  always_comb
  begin
    mapped = 1'b0;
    if (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0)
    begin
      unique case (regIdx)
        IDX_WDOG_CLEAR, IDX_POWER_CTRL, IDX_FETCH_WAIT, IDX_P1_WAKE,
        IDX_CAUSE_FLAGS, IDX_SOFT_RESET, IDX_DIV_SELECT,
        IDX_CLK_APPLY: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  logic [7:0] rdByte;
  always_comb
  begin
    rdByte = 8'h00;
    unique case (regIdx)
      IDX_POWER_CTRL: rdByte = {5'h00, gf0_r, stop_r, idle_r};
      IDX_FETCH_WAIT: rdByte = {1'b0, fetchWait_r, FETCH_LOW_BITS};
      IDX_P1_WAKE: rdByte = p1Wake_r;
      IDX_CAUSE_FLAGS: rdByte = {causeFlags_r, 5'h00};
      IDX_SOFT_RESET: rdByte = {7'h00, softFlag_r};
      IDX_DIV_SELECT: rdByte = {5'h00, divSelect_r};
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (clkEn)
    begin
      // answer in the first access cycle
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup && !pwrite && mapped) ? {24'h000000, rdByte} :
        32'h00000000;
    end
  end

  // reset sources
  logic lvdReq;
  logic pinLow;
  logic pinReq;
  logic srcActive;
  logic running;
  logic portChange;
  assign lvdReq = cfgLvdEn & lowSupply;
  assign pinLow = cfgPinResetEn & ~pinHigh;
  assign pinReq = pinLow & (~cfgDebounceEn | debDone_r);
  assign srcActive = lvdReq | pinReq | wdtFire_r;
  assign running = (seq_r == SEQ_RUN);
  assign portChange = |(syncOut_r[10:3] ^ port0Last_r) |
    |((syncOut_r[18:11] ^ port1Last_r) & p1Wake_r);

  // pin de-bounce: a low shorter than the window never raises a request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      debCnt_r <= '0;
      debDone_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!pinLow)
      begin
        debCnt_r <= '0;
        debDone_r <= 1'b0;
      end
      else if (debCnt_r == DEB_W'(DEBOUNCE_CYCLES - 1))
        debDone_r <= 1'b1;
      else
        debCnt_r <= debCnt_r + 1'b1;
    end
  end

  // power-on sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seq_r <= SEQ_POWER;
      seqCnt_r <= '0;
    end
    else if (clkEn)
    begin
      if (srcActive)
      begin
        seq_r <= SEQ_HOLD;
        seqCnt_r <= '0;
      end
      else
      begin
        unique case (seq_r)
          SEQ_HOLD:
          begin
            seq_r <= SEQ_POWER;
            seqCnt_r <= '0;
          end
          SEQ_POWER:
            if (seqCnt_r == SEQ_W'(PWR_STAB_CYCLES - 1))
            begin
              seq_r <= SEQ_OSC;
              seqCnt_r <= '0;
            end
            else
              seqCnt_r <= seqCnt_r + 1'b1;
          SEQ_OSC:
            if (seqCnt_r == SEQ_W'(OSC_WARM_CYC - 1))
            begin
              seq_r <= SEQ_SLOW;
              seqCnt_r <= '0;
            end
            else
              seqCnt_r <= seqCnt_r + 1'b1;
          SEQ_SLOW:
            if (slowTick)
            begin
              if (seqCnt_r == SEQ_W'(SLOW_WARM_TICKS - 1))
                seq_r <= SEQ_RUN;
              else
                seqCnt_r <= seqCnt_r + 1'b1;
            end
          SEQ_RUN:
            if (softReq_r)
              seq_r <= SEQ_SOFT;
          SEQ_SOFT:
            seq_r <= SEQ_RUN;
          // two codes of the state word are unused
          default:
            seq_r <= SEQ_HOLD;
        endcase
      end
    end
  end

  // cause flags survive the register initialisation
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      causeFlags_r <= 3'h0;
      softFlag_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (srcActive)
      begin
        // a new reset episode replaces the old cause
        if (seq_r != SEQ_HOLD)
          causeFlags_r <= {lvdReq, wdtFire_r, pinReq};
        else
          causeFlags_r <= causeFlags_r | {lvdReq, wdtFire_r, pinReq};
        softFlag_r <= 1'b0;
      end
      else if (running && softReq_r)
      begin
        causeFlags_r <= 3'h0;
        softFlag_r <= 1'b1;
      end
    end
  end

  // software registers, held at defaults outside normal running
  always_ff @(posedge clk)
  begin
    if (rst || (clkEn && !running))
    begin
      p1Wake_r <= P1_WAKE_RST;
      idle_r <= 1'b0;
      stop_r <= 1'b0;
      gf0_r <= 1'b0;
      divSelect_r <= DIV_SELECT_RST;
      divActive_r <= DIV_ACTIVE_RST;
      fetchWait_r <= FETCH_WAIT_RST;
      softArmed_r <= 1'b0;
      softReq_r <= 1'b0;
    end
    else if (clkEn)
    begin
      softReq_r <= 1'b0;
      if (idle_r && (portChange || irqEvent))
        idle_r <= 1'b0;
      if (stop_r && portChange)
        stop_r <= 1'b0;
      if (wrAccess)
      begin
        softArmed_r <= 1'b0;
        unique case (regIdx)
          IDX_POWER_CTRL:
          begin
            // a write in the wake cycle still wins
            idle_r <= wrByte[POWER_CONTROL_IDLE_BIT];
            stop_r <= wrByte[POWER_CONTROL_STOP_BIT];
            gf0_r <= wrByte[POWER_CONTROL_GF0_BIT];
          end
          IDX_FETCH_WAIT:
            fetchWait_r <= wrByte[FETCH_LSB +: 3];
          IDX_P1_WAKE:
            p1Wake_r <= wrByte;
          IDX_DIV_SELECT:
            divSelect_r <= wrByte[2:0];
          IDX_CLK_APPLY:
            // reserved codes are not applied
            if (wrByte == CLK_APPLY_CODE && divSelect_r <= DIV_SELECT_MAX)
              divActive_r <= divSelect_r;
          IDX_SOFT_RESET:
            if (wrByte[SOFTWARE_RESET_REGISTER_REQ_BIT])
            begin
              softArmed_r <= ~softArmed_r;
              softReq_r <= softArmed_r;
            end
          default:
          begin
          end
        endcase
      end
    end
  end

  // watchdog
  logic wdtCounting;
  logic [4:0] preMax;
  always_comb
  begin
    wdtCounting = 1'b0;
    if (running)
    begin
      if (cfgWdtMode == WDT_MODE_ALWAYS)
        wdtCounting = 1'b1;
      else if (cfgWdtMode == WDT_MODE_ENABLE)
        wdtCounting = ~idle_r & ~stop_r;
      else
        wdtCounting = 1'b0;
    end
  end
  assign preMax = 5'((6'h04 << cfgWdtPrescale) - 6'h01);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wdtPre_r <= 5'h00;
      wdtCnt_r <= 8'h00;
      wdtFire_r <= 1'b0;
    end
    else if (clkEn)
    begin
      wdtFire_r <= 1'b0;
      if (!running || (wrAccess && regIdx == IDX_WDOG_CLEAR &&
          wrByte == WDT_CLEAR_CODE))
      begin
        wdtPre_r <= 5'h00;
        wdtCnt_r <= 8'h00;
      end
      else if (wdtCounting && slowTick)
      begin
        if (wdtPre_r == preMax)
        begin
          wdtPre_r <= 5'h00;
          wdtCnt_r <= wdtCnt_r + 8'h01;
          if (wdtCnt_r == 8'(WDT_TICKS - 1))
            wdtFire_r <= 1'b1;
        end
        else
          wdtPre_r <= wdtPre_r + 5'h01;
      end
    end
  end

  // cpu clock divider and fetch stretch
  logic [6:0] divMax;
  logic cpuTick;
  logic oscOn;
  assign divMax = 7'((8'h80 >> divActive_r) - 8'h01);
  assign cpuTick = (divCnt_r == divMax) & oscOn;
  assign oscOn = (seq_r == SEQ_OSC || seq_r == SEQ_SLOW || running ||
    seq_r == SEQ_SOFT) && !stop_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      divCnt_r <= 7'h00;
      fetchCnt_r <= 3'h0;
    end
    else if (clkEn)
    begin
      // restart when the count is past a new ratio so no period overshoots
      if (!oscOn || cpuTick || divCnt_r > divMax)
        divCnt_r <= 7'h00;
      else
        divCnt_r <= divCnt_r + 7'h01;
      if (!running)
        fetchCnt_r <= 3'h0;
      else if (cpuTick && !idle_r)
        fetchCnt_r <= (fetchCnt_r >= fetchWait_r) ? 3'h0 :
          fetchCnt_r + 3'h1;
    end
  end

  // outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sysReset <= 1'b1;
      cpuRun <= 1'b0;
      cpuClkEn <= 1'b0;
      fetchEn <= 1'b0;
      periphRun <= 1'b0;
      fastOscRun <= 1'b0;
    end
    else if (clkEn)
    begin
      sysReset <= srcActive || seq_r == SEQ_HOLD || seq_r == SEQ_SOFT;
      cpuRun <= running && !srcActive && !softReq_r;
      // no cpu edge in the cycle that a reset is raised
      cpuClkEn <= running && !srcActive && !softReq_r && cpuTick &&
        !idle_r;
      fetchEn <= running && !srcActive && !softReq_r && cpuTick &&
        !idle_r && fetchCnt_r >= fetchWait_r;
      periphRun <= running && oscOn;
      fastOscRun <= oscOn;
    end
  end
endmodule

// >>> rcpc_top_asserts.sv
`timescale 1ns/100ps
module rcpc_top_asserts
#(
  parameter int PWR_STAB_CYCLES = 20
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // straps and pins
  input wire logic cfgLvdEn,
  input wire logic cfgPinResetEn,
  input wire logic cfgDebounceEn,
  input wire logic supplyLow,
  input wire logic resetPinN,
  // system controls
  input wire logic sysReset,
  input wire logic cpuRun,
  input wire logic cpuClkEn,
  input wire logic fetchEn,
  input wire logic periphRun,
  input wire logic fastOscRun
);
  int lowCnt;
  always_ff @(posedge clk)
  begin
    if (rst || cpuRun)
      lowCnt <= 0;
    else
      lowCnt <= lowCnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET_HOLD: assert property (disable iff (1'b0)
    rst |=> sysReset && !cpuRun) else $error("reset not held");
  AST_RUN_AFTER_SEQ: assert property ($rose(cpuRun) && lowCnt > 8
    |-> lowCnt >= PWR_STAB_CYCLES + 2048) else $error("run too early");
  AST_PIN_FAST: assert property (cfgPinResetEn && !cfgDebounceEn
    && $fell(resetPinN) |-> ##[1:5] sysReset) else $error("pin reset late");
  AST_LVD: assert property (cfgLvdEn && supplyLow [*5]
    |-> sysReset) else $error("low supply no reset");
  AST_NO_RUN: assert property (sysReset [*2] |-> !cpuRun)
    else $error("run during reset");
  AST_CPU_CLK: assert property (cpuClkEn
    |-> cpuRun && periphRun && fastOscRun) else $error("cpu clock gating");
  AST_FETCH: assert property (fetchEn |-> cpuRun)
    else $error("fetch while halted");
  AST_STOP: assert property (cpuRun && !fastOscRun |-> !periphRun)
    else $error("peripherals run in stop");
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("pready late");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("pready stands too long");
  AST_SLVERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
endmodule

// >>> rcpc_far_model.sv
`timescale 1ns/100ps
module rcpc_far_model
#(
  parameter int HALF_CYC = 8
)
(
  // clock
  input wire logic clk,
  // slow oscillator
  output logic slowOscClk
);
  int cnt = 0;
  initial slowOscClk = 1'b0;
  // scaled up so watchdog periods fit the run
  always @(posedge clk)
  begin
    cnt <= (cnt == HALF_CYC - 1) ? 0 : cnt + 1;
    if (cnt == HALF_CYC - 1)
      slowOscClk <= ~slowOscClk;
  end
endmodule

// >>> reset_clock_power_controller_tb.sv
`timescale 1ns/100ps
module reset_clock_power_controller_tb;
  import rcpc_pkg::*;
  typedef struct {
    logic [7:0] idx;
    logic wr;
    logic [7:0] wd;
    logic [31:0] exp;
    logic err;
  } rcpc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic cfgLvdEn = 1'b0;
  logic cfgPinResetEn = 1'b1;
  logic cfgDebounceEn = 1'b0;
  logic [1:0] cfgWdtMode = WDT_MODE_OFF;
  logic supplyLow = 1'b0;
  logic resetPinN = 1'b1;
  logic [7:0] port0In = 8'h00;
  logic [7:0] port1In = 8'h00;
  logic irqEvent = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, slowOscClk, sysReset, cpuRun;
  logic cpuClkEn, fetchEn, periphRun, fastOscRun;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  rcpc_row_t rows [11] = '{
    '{IDX_CAUSE_FLAGS, 1'b0, 8'h00, 32'h0, 1'b0},
    '{IDX_SOFT_RESET, 1'b0, 8'h00, 32'h0, 1'b0},
    '{IDX_FETCH_WAIT, 1'b0, 8'h00, 32'h71, 1'b0},
    '{IDX_DIV_SELECT, 1'b0, 8'h00, 32'h7, 1'b0},
    '{IDX_POWER_CTRL, 1'b0, 8'h00, 32'h0, 1'b0},
    '{IDX_P1_WAKE, 1'b0, 8'h00, 32'h0, 1'b0},
    '{IDX_P1_WAKE, 1'b1, 8'ha5, 32'h0, 1'b0},
    '{IDX_P1_WAKE, 1'b0, 8'h00, 32'ha5, 1'b0},
    '{IDX_CAUSE_FLAGS, 1'b1, 8'hff, 32'h0, 1'b0},
    '{IDX_CAUSE_FLAGS, 1'b0, 8'h00, 32'h0, 1'b0},
    '{8'h10, 1'b0, 8'h00, 32'h0, 1'b1}
  };
  always #25 clk = ~clk;
  rcpc_far_model i_far (.clk(clk), .slowOscClk(slowOscClk));
  rcpc_top #(.PWR_STAB_CYCLES(20), .DEBOUNCE_CYCLES(10)) i_dut (
    .clk(clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfgLvdEn(cfgLvdEn),
    .cfgPinResetEn(cfgPinResetEn), .cfgDebounceEn(cfgDebounceEn),
    .cfgWdtMode(cfgWdtMode), .cfgWdtPrescale(2'h0),
    .supplyLow(supplyLow), .resetPinN(resetPinN),
    .slowOscClk(slowOscClk), .port0In(port0In), .port1In(port1In),
    .irqEvent(irqEvent), .sysReset(sysReset), .cpuRun(cpuRun),
    .cpuClkEn(cpuClkEn), .fetchEn(fetchEn), .periphRun(periphRun),
    .fastOscRun(fastOscRun));
  task automatic results();
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic [7:0] idx, input logic wr,
    input logic [7:0] wd, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    paddr <= {2'b00, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic err;
    apb(idx, 1'b1, wd, rd, err);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx,
    input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(idx, 1'b0, 8'h00, rd, err);
    chk(nm, rd, exp);
  endtask
  task automatic waitRun();
    int k;
    k = 0;
    repeat (2) @(posedge clk);
    while (cpuRun !== 1'b1 && k < 20000)
    begin
      @(posedge clk);
      k++;
    end
    chk("cpuRun", cpuRun, 1);
  endtask
  // second span only: the first may straddle a divider change
  task automatic period(input logic f, output int p);
    repeat (2)
    begin
      p = 0;
      while ((f ? fetchEn : cpuClkEn) !== 1'b1) @(posedge clk);
      @(posedge clk);
      while ((f ? fetchEn : cpuClkEn) !== 1'b1 && p < 2000)
      begin
        p++;
        @(posedge clk);
      end
      p++;
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      errors++;
      results();
    end
  end
  initial
  begin
    logic [31:0] rd;
    logic err;
    repeat (2) @(posedge clk);
    chk("sysReset", sysReset, 1);
    rst <= 1'b0;
    waitRun();
    foreach (rows[i])
    begin
      apb(rows[i].idx, rows[i].wr, rows[i].wd, rd, err);
      chk("regData", rd, rows[i].exp);
      chk("regErr", err, rows[i].err);
    end
    wr(IDX_DIV_SELECT, 8'h05);
    period(1'b0, n);
    chk("div128", n, 128);
    wr(IDX_CLK_APPLY, CLK_APPLY_CODE);
    period(1'b0, n);
    chk("div4", n, 4);
    period(1'b1, n);
    chk("fetch8", n, 32);
    wr(IDX_FETCH_WAIT, 8'h00);
    period(1'b1, n);
    chk("fetch1", n, 4);
    wr(IDX_DIV_SELECT, 8'h04);
    wr(IDX_CLK_APPLY, 8'h33);
    period(1'b0, n);
    chk("divKeep", n, 4);
    wr(IDX_CLK_APPLY, CLK_APPLY_CODE);
    period(1'b0, n);
    chk("div8", n, 8);
    wr(IDX_POWER_CTRL, 8'h01);
    n = 0;
    repeat (100)
    begin
      @(posedge clk);
      if (cpuClkEn === 1'b1)
        n++;
    end
    chk("idleClk", n, 0);
    chk("idlePeriph", periphRun, 1);
    port1In[1] <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk("maskedWake", IDX_POWER_CTRL, 32'h1);
    port1In[0] <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk("portWake", IDX_POWER_CTRL, 32'h0);
    wr(IDX_POWER_CTRL, 8'h01);
    irqEvent <= 1'b1;
    @(posedge clk);
    irqEvent <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk("irqWake", IDX_POWER_CTRL, 32'h0);
    wr(IDX_POWER_CTRL, 8'h02);
    repeat (4) @(posedge clk);
    chk("stopOsc", fastOscRun, 0);
    chk("stopPeriph", periphRun, 0);
    irqEvent <= 1'b1;
    @(posedge clk);
    irqEvent <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk("stopIrq", IDX_POWER_CTRL, 32'h2);
    port0In[3] <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk("stopWake", IDX_POWER_CTRL, 32'h0);
    wr(IDX_SOFT_RESET, 8'h01);
    wr(IDX_SOFT_RESET, 8'h00);
    wr(IDX_SOFT_RESET, 8'h01);
    chk("softArm", cpuRun, 1);
    wr(IDX_SOFT_RESET, 8'h01);
    n = 0;
    repeat (20)
    begin
      @(posedge clk);
      if (cpuRun !== 1'b1)
        n++;
    end
    chk("softShort", n > 0 && n < 8, 1);
    rdchk("softFlag", IDX_SOFT_RESET, 32'h1);
    rdchk("softInit", IDX_P1_WAKE, 32'h0);
    resetPinN <= 1'b0;
    repeat (6) @(posedge clk);
    chk("pinReset", sysReset, 1);
    repeat (20) @(posedge clk);
    resetPinN <= 1'b1;
    waitRun();
    rdchk("pinFlag", IDX_CAUSE_FLAGS, 32'h20);
    cfgDebounceEn <= 1'b1;
    resetPinN <= 1'b0;
    repeat (6) @(posedge clk);
    resetPinN <= 1'b1;
    repeat (20) @(posedge clk);
    chk("bounce", sysReset, 0);
    resetPinN <= 1'b0;
    repeat (30) @(posedge clk);
    chk("debounced", sysReset, 1);
    resetPinN <= 1'b1;
    waitRun();
    cfgLvdEn <= 1'b1;
    supplyLow <= 1'b1;
    repeat (10) @(posedge clk);
    chk("lvdReset", sysReset, 1);
    supplyLow <= 1'b0;
    waitRun();
    rdchk("lvdFlag", IDX_CAUSE_FLAGS, 32'h80);
    cfgWdtMode <= WDT_MODE_ENABLE;
    wr(IDX_WDOG_CLEAR, WDT_CLEAR_CODE);
    n = 0;
    while (sysReset !== 1'b1 && n < 30000)
    begin
      @(posedge clk);
      n++;
      if (n == 8000)
        wr(IDX_WDOG_CLEAR, 8'h33);
    end
    chk("wdtTime", n > 16300 && n < 16450, 1);
    cfgWdtMode <= WDT_MODE_OFF;
    waitRun();
    rdchk("wdtFlag", IDX_CAUSE_FLAGS, 32'h40);
    clkEn <= 1'b0;
    resetPinN <= 1'b0;
    repeat (30) @(posedge clk);
    chk("freezeReset", sysReset, 0);
    resetPinN <= 1'b1;
    repeat (2) @(posedge clk);
    clkEn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("thawRun", cpuRun, 1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    waitRun();
    rdchk("rstFlag", IDX_CAUSE_FLAGS, 32'h0);
    results();
  end
endmodule
bind rcpc_top rcpc_top_asserts #(.PWR_STAB_CYCLES(PWR_STAB_CYCLES)) i_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cfgLvdEn(cfgLvdEn),
  .cfgPinResetEn(cfgPinResetEn), .cfgDebounceEn(cfgDebounceEn),
  .supplyLow(supplyLow), .resetPinN(resetPinN), .sysReset(sysReset),
  .cpuRun(cpuRun), .cpuClkEn(cpuClkEn), .fetchEn(fetchEn),
  .periphRun(periphRun), .fastOscRun(fastOscRun));
